// [core/bfm_pkg.sv]
package bfm_pkg;

  localparam int NUM_GRP = 8;
  localparam int NUM_OUT = 4;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CNT_A = 8'h0C;
  localparam logic [7:0] OFS_CNT_B = 8'h10;
  localparam logic [7:0] OFS_PREF = 8'h14;
  localparam logic [7:0] OFS_GRP = 8'h40;
  localparam int GRP_IDX_LSB = 3;
  localparam int GRP_WORD_BIT = 2;

  localparam int CLK_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int TICK_MS = 5;
  localparam int PREF_MS = 20;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int TICK_CYC = TICK_MS * MS_CYC;
  localparam int PREF_TAPS = PREF_MS / TICK_MS;
  localparam int HIST_LEN = 2 * PREF_TAPS - 1;
  localparam int RESET_PCT = 97;
  localparam int FULL_PCT = 100;

  localparam logic [2:0] NM_ON = 3'h1, NM_BLK = 3'h2, NM_TEST = 3'h3, NM_TBLK = 3'h4, NM_OFF = 3'h5;
  localparam logic [2:0] FS_NORMAL = 3'h0, FS_START = 3'h1, FS_RETRIP = 3'h2, FS_FAIL = 3'h3,
                         FS_BLOCKED = 3'h4;
  localparam logic [1:0] RS_NONE = 2'h0, RS_ONE = 2'h1, RS_TWO = 2'h2, RS_CALC = 2'h3;
  localparam logic [3:0] AM_CUR = 4'h0, AM_DO = 4'h1, AM_SIG = 4'h2, AM_C_AND_D = 4'h3,
                         AM_C_OR_D = 4'h4, AM_C_OR_S = 4'h5, AM_C_AND_S = 4'h6, AM_S_AND_D = 4'h7,
                         AM_S_OR_D = 4'h8, AM_ANY = 4'h9, AM_ALL = 4'hA;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_BLOCKED} bfm_state_type;

  typedef struct packed {
    logic [1:0] res_sel;
    logic       force_allow;
    logic       mode_allow;
    logic [2:0] force_st;
    logic [2:0] node_mode;
  } bfm_ctrl_type;

  typedef struct packed {
    logic       retrip_en;
    logic [3:0] act_mode;
    logic [9:0] fail_ticks;
    logic [9:0] retrip_ticks;
  } bfm_tim_type;

  typedef struct packed {
    logic [15:0] phase_a_rms;
    logic [15:0] phase_b_rms;
    logic [15:0] phase_c_rms;
    logic [15:0] residual_one_rms;
    logic [15:0] residual_two_rms;
    logic [15:0] computed_residual;
  } bfm_meas_type;

  typedef struct packed {
    logic start;
    logic retrip;
    logic failure_active_output;
    logic blocked;
  } bfm_out_type;

  typedef struct packed {
    logic        valid;
    logic        is_on;
    logic [1:0]  sig;
    logic [31:0] stamp;
  } bfm_event_type;

  localparam bfm_ctrl_type CTRL_RST = '{res_sel: RS_NONE, force_allow: 1'b0, mode_allow: 1'b0,
                                        force_st: FS_NORMAL, node_mode: NM_ON};
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] THR_RST = 32'h0600_0100;
  localparam bfm_tim_type TIM_RST = '{retrip_en: 1'b1, act_mode: AM_CUR, fail_ticks: 10'h028,
                                      retrip_ticks: 10'h014};

endpackage : bfm_pkg

// [core/bfm_breaker_failure_supervision.sv]
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Trigger by current, relay, signal, or combination.
// - Current mode evaluates three phases plus residual.
// - Signal mode accepts any masked binary signal.
// - Relay mode watches chosen relay control signals.
// - Eight setting groups from one common selector.
// - Group and blocking change parameters while running.
// - Retrip failing breaker, then backup failure output.
// - Outputs start, retrip, failure active, blocked.
// - ON/OFF output events stamped to one millisecond.
// - Resettable counters for all four outputs.
// - RMS inputs; residual source selectable among three.
// - Measurements evaluated on a five millisecond base.
// - Pre-fault average of 20 ms, 20 ms earlier.
// - Signal triggers count only in signal modes.
// - Relay triggers count only in relay modes.
// - General mode settings unaffected by group change.
// - Node mode On/Blocked/Test/TestBlocked/Off, gated globally.
// - Forced status Normal/Start/Retrip/Failure/Blocked, gated globally.
// - Pick-up above threshold, release at 97 percent.
// - Blocking at pick-up gives blocked, not start.
// - Operating mode combines sources by AND/OR.
// - One pick-up starts retrip and failure timers.
module bfm_breaker_failure_supervision #(
  parameter int TICK_CYC = bfm_pkg::TICK_CYC,
  parameter int MS_CYC   = bfm_pkg::MS_CYC
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire bfm_pkg::bfm_meas_type  meas_in,
  input  wire logic [15:0]            output_relay_monitor_in,
  input  wire logic [15:0]            digital_input_monitor_in,
  input  wire logic                   block_in,
  input  wire logic [2:0]             group_sel_in,
  output bfm_pkg::bfm_out_type        outs,
  output bfm_pkg::bfm_event_type      event_out
);

  bfm_pkg::bfm_ctrl_type  ctrl_q;
  bfm_pkg::bfm_tim_type   tim_q [bfm_pkg::NUM_GRP];
  bfm_pkg::bfm_tim_type   tim;
  bfm_pkg::bfm_state_type state_q;
  bfm_pkg::bfm_out_type   out_d;
  logic [31:0]            mask_q;
  logic [31:0]            thr_q [bfm_pkg::NUM_GRP];
  logic [2:0]             gsel_q;
  logic                   a_wr_q;
  logic [7:0]             a_addr_q;
  logic                   map_ok;
  logic [31:0]            rd_word;
  logic [31:0]            tick_cnt_q;
  logic [31:0]            ms_cnt_q;
  logic [31:0]            ms_stamp_q;
  logic                   tick_q;
  logic                   cur_q;
  logic                   cur_hit;
  logic                   do_hit;
  logic                   sig_hit;
  logic                   trig;
  logic [15:0]            res_mag;
  logic [2:0]             mode_eff;
  logic                   blk;
  logic                   off;
  logic                   force_on;
  logic [9:0]             timer_q;
  logic [15:0]            cnt_q [bfm_pkg::NUM_OUT];
  logic                   clr_a;
  logic                   clr_b;
  logic [3:0]             ov_d;
  logic [3:0]             ov_q;
  logic [7:0]             pend_q;
  logic [7:0]             pend_sel;
  logic [2:0]             pend_idx;
  logic [15:0]            hist_q [bfm_pkg::HIST_LEN];
  logic [15:0]            pref_q;
  logic [15:0]            pref_avg;
  logic [15:0]            mag_now;

  function automatic logic grp_hit(input logic [7:0] a);
    grp_hit = a >= bfm_pkg::OFS_GRP;
  endfunction : grp_hit

  function automatic logic above(input logic [15:0] c, input logic [15:0] t, input logic held);
    if (held)
    begin
      above = 24'(c) * 24'(bfm_pkg::FULL_PCT) >= 24'(t) * 24'(bfm_pkg::RESET_PCT);
    end
    else
    begin
      above = c > t;
    end
  endfunction : above

  function automatic logic [15:0] max2(input logic [15:0] a, input logic [15:0] b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  function automatic logic act(input logic [3:0] m, input logic c, input logic d, input logic s);
    case (m)
      bfm_pkg::AM_CUR:     act = c;
      bfm_pkg::AM_DO:      act = d;
      bfm_pkg::AM_SIG:     act = s;
      bfm_pkg::AM_C_AND_D: act = c & d;
      bfm_pkg::AM_C_OR_D:  act = c | d;
      bfm_pkg::AM_C_OR_S:  act = c | s;
      bfm_pkg::AM_C_AND_S: act = c & s;
      bfm_pkg::AM_S_AND_D: act = s & d;
      bfm_pkg::AM_S_OR_D:  act = s | d;
      bfm_pkg::AM_ANY:     act = c | d | s;
      bfm_pkg::AM_ALL:     act = c & d & s;
      default:             act = 1'b0;
    endcase
  endfunction : act

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus slave. Zero wait states; a write lands at the end of its data phase.

  assign map_ok = hsel && htrans[1] && hready && (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
  assign clr_a  = a_wr_q && (a_addr_q == bfm_pkg::OFS_CNT_A);
  assign clr_b  = a_wr_q && (a_addr_q == bfm_pkg::OFS_CNT_B);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_wr_q    <= 1'b0;
      a_addr_q  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      a_wr_q    <= map_ok && hwrite;
      a_addr_q  <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (map_ok && !hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (haddr[7:0] == bfm_pkg::OFS_CTRL)
      rd_word = {22'h00_0000, ctrl_q};
    else if (haddr[7:0] == bfm_pkg::OFS_MASK)
      rd_word = mask_q;
    else if (haddr[7:0] == bfm_pkg::OFS_STAT)
      rd_word = {6'h00, timer_q, 4'h0, gsel_q, cur_q, 2'h0, state_q, outs};
    else if (haddr[7:0] == bfm_pkg::OFS_CNT_A)
      rd_word = {cnt_q[3], cnt_q[2]};
    else if (haddr[7:0] == bfm_pkg::OFS_CNT_B)
      rd_word = {cnt_q[1], cnt_q[0]};
    else if (haddr[7:0] == bfm_pkg::OFS_PREF)
      rd_word = {16'h0000, pref_q};
    else if (grp_hit(haddr[7:0]))
      rd_word = haddr[bfm_pkg::GRP_WORD_BIT] ? {7'h00, tim_q[haddr[5:3]]} : thr_q[haddr[5:3]];
  end

  // General settings live outside the groups so a group switch never touches them.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= bfm_pkg::CTRL_RST;
      mask_q <= bfm_pkg::MASK_RST;
    end
    else if (a_wr_q && a_addr_q == bfm_pkg::OFS_CTRL)
      ctrl_q <= hwdata[9:0];
    else if (a_wr_q && a_addr_q == bfm_pkg::OFS_MASK)
      mask_q <= hwdata;
  end

  for (genvar g = 0; g < bfm_pkg::NUM_GRP; g++)
  begin : g_grp
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        thr_q[g] <= bfm_pkg::THR_RST;
        tim_q[g] <= bfm_pkg::TIM_RST;
      end
      else if (a_wr_q && grp_hit(a_addr_q) && a_addr_q[5:3] == 3'(g))
      begin
        if (a_addr_q[bfm_pkg::GRP_WORD_BIT])
          tim_q[g] <= hwdata[24:0];
        else
          thr_q[g] <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Time bases.

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q     <= tick_cnt_q == 32'(TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ms_cnt_q   <= 32'h0000_0000;
      ms_stamp_q <= 32'h0000_0000;
    end
    else if (ms_cnt_q == 32'(MS_CYC - 1))
    begin
      ms_cnt_q   <= 32'h0000_0000;
      ms_stamp_q <= ms_stamp_q + 32'h1;
    end
    else
      ms_cnt_q <= ms_cnt_q + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Pick-up. The live group is read every tick, so a group switch retunes a running supervision.

  assign tim = tim_q[gsel_q];

  always_comb
  begin
    case (ctrl_q.res_sel)
      bfm_pkg::RS_ONE:  res_mag = meas_in.residual_one_rms;
      bfm_pkg::RS_TWO:  res_mag = meas_in.residual_two_rms;
      bfm_pkg::RS_CALC: res_mag = meas_in.computed_residual;
      default:          res_mag = 16'h0000;
    endcase
  end

  assign cur_hit = above(meas_in.phase_a_rms, thr_q[gsel_q][15:0], cur_q)
                 | above(meas_in.phase_b_rms, thr_q[gsel_q][15:0], cur_q)
                 | above(meas_in.phase_c_rms, thr_q[gsel_q][15:0], cur_q)
                 | ((ctrl_q.res_sel != bfm_pkg::RS_NONE) && above(res_mag, thr_q[gsel_q][31:16], cur_q));
  assign sig_hit = |(digital_input_monitor_in & mask_q[15:0]);
  assign do_hit  = |(output_relay_monitor_in & mask_q[31:16]);
  assign trig    = act(tim.act_mode, cur_hit, do_hit, sig_hit);

  assign mode_eff = ctrl_q.mode_allow ? ctrl_q.node_mode : bfm_pkg::NM_ON;
  assign off      = mode_eff == bfm_pkg::NM_OFF;
  assign blk      = block_in || mode_eff == bfm_pkg::NM_BLK || mode_eff == bfm_pkg::NM_TBLK;
  assign force_on = ctrl_q.force_allow && ctrl_q.force_st != bfm_pkg::FS_NORMAL;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gsel_q <= 3'h0;
      cur_q  <= 1'b0;
    end
    else
    begin
      gsel_q <= group_sel_in;
      if (tick_q)
        cur_q <= cur_hit && !off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Supervision sequence. Blocking is sampled only on the tick, at the head of each cycle.

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= bfm_pkg::ST_IDLE;
      timer_q <= 10'h000;
    end
    else if (tick_q)
    begin
      case (state_q)
        bfm_pkg::ST_IDLE:
        begin
          timer_q <= 10'h000;
          if (trig && !off)
            state_q <= blk ? bfm_pkg::ST_BLOCKED : bfm_pkg::ST_RUN;
        end
        bfm_pkg::ST_RUN:
        begin
          if (!trig || off)
            state_q <= bfm_pkg::ST_IDLE;
          else if (blk)
            state_q <= bfm_pkg::ST_BLOCKED;
          else if (timer_q != 10'h3FF)
            timer_q <= timer_q + 10'h001;
        end
        default:
        begin
          timer_q <= 10'h000;
          if (!trig || off)
            state_q <= bfm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    out_d = '0;
    out_d.start                 = state_q == bfm_pkg::ST_RUN;
    out_d.retrip                = out_d.start && tim.retrip_en && timer_q >= tim.retrip_ticks;
    out_d.failure_active_output = out_d.start && timer_q >= tim.fail_ticks;
    out_d.blocked               = state_q == bfm_pkg::ST_BLOCKED;
    if (force_on)
    begin
      out_d = '0;
      case (ctrl_q.force_st)
        bfm_pkg::FS_START:  out_d.start = 1'b1;
        bfm_pkg::FS_RETRIP: out_d.retrip = 1'b1;
        bfm_pkg::FS_FAIL:   out_d.failure_active_output = 1'b1;
        default:            out_d.blocked = 1'b1;
      endcase
    end
  end

  assign ov_d = out_d;
  assign ov_q = outs;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      outs <= '0;
    else
      outs <= out_d;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Counters, events and pre-fault history.

  for (genvar k = 0; k < bfm_pkg::NUM_OUT; k++)
  begin : g_cnt
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        cnt_q[k] <= 16'h0000;
      else if (ov_d[k] && !ov_q[k])
        cnt_q[k] <= cnt_q[k] + 16'h0001;
      else if ((k >= 2) ? clr_a : clr_b)
        cnt_q[k] <= 16'h0000;
    end
  end

  always_comb
  begin
    pend_idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (pend_q[i])
        pend_idx = 3'(i);
    end
    pend_sel = (|pend_q) ? (8'h01 << pend_idx) : 8'h00;
  end

  // A new edge may arrive while the same bit drains; it is kept rather than lost.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q    <= 8'h00;
      event_out <= '0;
    end
    else
    begin
      pend_q          <= (pend_q & ~pend_sel) | {ov_q & ~ov_d, ov_d & ~ov_q};
      event_out.valid <= |pend_q;
      event_out.is_on <= !pend_idx[2];
      event_out.sig   <= pend_idx[1:0];
      event_out.stamp <= ms_stamp_q;
    end
  end

  assign mag_now = max2(max2(meas_in.phase_a_rms, meas_in.phase_b_rms), max2(meas_in.phase_c_rms, res_mag));

  always_comb
  begin
    logic [17:0] sum;
    sum = 18'h00000;
    for (int i = bfm_pkg::PREF_TAPS - 1; i < bfm_pkg::HIST_LEN; i++)
      sum = sum + 18'(hist_q[i]);
    pref_avg = sum[17:2];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < bfm_pkg::HIST_LEN; i++)
        hist_q[i] <= 16'h0000;
      pref_q <= 16'h0000;
    end
    else if (tick_q)
    begin
      hist_q[0] <= mag_now;
      for (int i = 1; i < bfm_pkg::HIST_LEN; i++)
        hist_q[i] <= hist_q[i - 1];
      if (state_q == bfm_pkg::ST_IDLE && trig && !off && !blk)
        pref_q <= pref_avg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_blk_pick;
    tick_q && state_q == bfm_pkg::ST_IDLE && trig && blk && !off && !force_on;
  endsequence

  sequence s_blk_seen;
    state_q == bfm_pkg::ST_BLOCKED ##1 (outs.blocked && !outs.start);
  endsequence

  property p_blk_pick;
    s_blk_pick |=> s_blk_seen;
  endproperty
  a_blk_pick: assert property (p_blk_pick) else $error("Blocked pick-up did not give blocked.");

  property p_tick_only;
    state_q != $past(state_q) |-> $past(tick_q);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("State moved off the time base.");

  property p_off_idle;
    tick_q && off |=> state_q == bfm_pkg::ST_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Off mode left supervision active.");

  property p_retrip_dis;
    !force_on && !tim.retrip_en |=> !outs.retrip;
  endproperty
  a_retrip_dis: assert property (p_retrip_dis) else $error("Retrip issued while disabled.");

  property p_fail_time;
    !force_on && state_q == bfm_pkg::ST_RUN && timer_q >= tim.fail_ticks |=> outs.failure_active_output;
  endproperty
  a_fail_time: assert property (p_fail_time) else $error("Failure output late.");

  property p_force;
    force_on && ctrl_q.force_st == bfm_pkg::FS_RETRIP |=> outs.retrip && !outs.start && !outs.blocked;
  endproperty
  a_force: assert property (p_force) else $error("Forced retrip not shown.");

  property p_cnt;
    ov_d[3] && !ov_q[3] |=> cnt_q[3] == $past(cnt_q[3]) + 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("Start counter missed an occurrence.");

  property p_event;
    $rose(outs.failure_active_output) |-> ##[0:8] (event_out.valid && event_out.is_on);
  endproperty
  a_event: assert property (p_event) else $error("No ON event after output rose.");

  property p_sig_only;
    tick_q && state_q == bfm_pkg::ST_IDLE && tim.act_mode == bfm_pkg::AM_SIG && !sig_hit
      |=> state_q == bfm_pkg::ST_IDLE;
  endproperty
  a_sig_only: assert property (p_sig_only) else $error("Start without a selected signal.");

  property p_pref;
    $past(tick_q) && $past(state_q) == bfm_pkg::ST_IDLE && state_q == bfm_pkg::ST_RUN
      |-> pref_q == $past(pref_avg);
  endproperty
  a_pref: assert property (p_pref) else $error("Pre-fault value not captured.");

endmodule : bfm_breaker_failure_supervision
`default_nettype wire

// [testbench/bfm_feeder_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bfm_feeder_model (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic [15:0]       fault_lvl,
  input  wire logic              brk_ok,
  input  wire logic              trip_cmd,
  output var bfm_pkg::bfm_meas_type meas
);
  logic open_q;
  // A healthy breaker opens on a trip command and stays open until the fault is removed.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      open_q <= 1'b0;
    else if (fault_lvl == 16'h0000)
      open_q <= 1'b0;
    else if (brk_ok && trip_cmd)
      open_q <= 1'b1;
  end
  // Only the computed residual carries a small standing value, so a wrong source choice is not hidden by zeros.
  always_comb
  begin
    meas = '0;
    meas.phase_a_rms = open_q ? 16'h0000 : fault_lvl;
    meas.computed_residual = 16'h0001;
  end
endmodule : bfm_feeder_model
`default_nettype wire

// [testbench/breaker_failure_monitor_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module breaker_failure_monitor_tb_top;
  logic                  hclk = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel = 1'b0;
  logic [31:0]           haddr = 32'h0;
  logic [1:0]            htrans = 2'h0;
  logic                  hwrite = 1'b0;
  logic [2:0]            hsize = 3'h2;
  logic [31:0]           hwdata = 32'h0;
  logic                  hreadyout;
  logic                  hresp;
  logic [31:0]           hrdata;
  logic [31:0]           rd_smp;
  bfm_pkg::bfm_meas_type meas;
  logic [15:0]           relay = 16'h0;
  logic [15:0]           din = 16'h0;
  logic                  block_in = 1'b0;
  logic [2:0]            grp = 3'h0;
  logic [15:0]           lvl = 16'h0;
  logic                  brk_ok = 1'b0;
  bfm_pkg::bfm_out_type  outs;
  bfm_pkg::bfm_event_type event_out;
  int                    error_cnt = 0;
  int                    tests_run = 0;
  int                    on_cnt = 0;
  int                    on_base = 0;
  logic [31:0]           start_ms = 32'h0;
  logic [31:0]           fail_ms = 32'h0;
  logic [31:0]           d;

  initial
  begin
    forever #10 hclk = ~hclk;
  end

  bfm_breaker_failure_supervision #(.TICK_CYC(20), .MS_CYC(4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas_in(meas), .output_relay_monitor_in(relay), .digital_input_monitor_in(din),
    .block_in(block_in), .group_sel_in(grp), .outs(outs), .event_out(event_out));

  bfm_feeder_model feeder_u (.hclk(hclk), .hresetn(hresetn), .fault_lvl(lvl), .brk_ok(brk_ok),
    .trip_cmd(outs.retrip), .meas(meas));

  // Read data is captured at the edge that ends the data phase, before the slave clears it.
  always @(posedge hclk)
  begin
    rd_smp <= hrdata;
    if (event_out.valid === 1'b1 && event_out.is_on === 1'b1)
    begin
      on_cnt <= on_cnt + 1;
      if (event_out.sig == 2'h3)
        start_ms <= event_out.stamp;
      if (event_out.sig == 2'h1)
        fail_ms <= event_out.stamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    #1 d = rd_smp;
  endtask : ahb_xfer

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chk_reg(input logic [31:0] a, input logic [31:0] exp);
    ahb_xfer(a, 1'b0, 32'h0);
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : chk_reg

  task chk_stat(input logic [3:0] exp);
    ahb_xfer(bfm_pkg::OFS_STAT, 1'b0, 32'h0);
    chk({28'h0, d[3:0]}, {28'h0, exp});
  endtask : chk_stat

  task ticks(input int n);
    repeat (n * 20) @(posedge hclk);
  endtask : ticks

  task final_report;
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(20 * 60000);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reg(32'h00, 32'h0000_0001);
    chk_reg(32'h04, 32'h0000_0000);
    chk_reg(32'h40, 32'h0600_0100);
    chk_reg(32'h44, 32'h0100_A014);
    chk_reg(32'h7C, 32'h0100_A014);
    chk_reg(32'h100, 32'h0000_0000);
    // Short timers keep the run brief: retrip after 2 ticks, failure after 4.
    ahb_xfer(32'h44, 1'b1, 32'h0100_1002);
    ahb_xfer(32'h4C, 1'b1, 32'h0010_1002);
    ahb_xfer(32'h54, 1'b1, 32'h0120_1002);
    ahb_xfer(32'h04, 1'b1, 32'h0001_0001);
    on_base = on_cnt;
    lvl <= 16'h0200;
    ticks(8);
    chk_stat(4'b1110);
    chk(32'(on_cnt - on_base), 32'd3);
    chk(fail_ms - start_ms, 32'(4 * bfm_pkg::TICK_MS));
    lvl <= 16'h00F9;
    ticks(3);
    chk_stat(4'b1110);
    lvl <= 16'h00F8;
    ticks(3);
    chk_stat(4'b0000);
    chk_reg(32'h0C, 32'h0001_0001);
    chk_reg(32'h10, 32'h0001_0000);
    brk_ok <= 1'b1;
    lvl <= 16'h0200;
    ticks(8);
    chk_stat(4'b0000);
    chk_reg(32'h10, 32'h0001_0000);
    chk_reg(32'h14, 32'h0000_013A);
    brk_ok <= 1'b0;
    lvl <= 16'h0000;
    block_in <= 1'b1;
    ticks(2);
    lvl <= 16'h0200;
    ticks(3);
    chk_stat(4'b0001);
    chk_reg(32'h10, 32'h0001_0001);
    block_in <= 1'b0;
    lvl <= 16'h0000;
    ticks(3);
    ahb_xfer(32'h0C, 1'b1, 32'h0000_0000);
    chk_reg(32'h0C, 32'h0000_0000);
    din <= 16'h0001;
    ticks(3);
    chk_stat(4'b0000);
    grp <= 3'h2;
    ticks(3);
    chk_stat(4'b1100);
    // Switching group mid-run keeps the supervision going under the new group's settings.
    din <= 16'h0000;
    relay <= 16'h0001;
    grp <= 3'h1;
    ticks(1);
    chk_stat(4'b1000);
    chk({29'h0, d[11:9]}, 32'h1);
    relay <= 16'h0000;
    ticks(3);
    relay <= 16'h0001;
    ticks(8);
    chk_stat(4'b1010);
    relay <= 16'h0000;
    grp <= 3'h0;
    ticks(3);
    ahb_xfer(32'h00, 1'b1, 32'h0000_0091);
    ticks(1);
    chk_stat(4'b0100);
    ahb_xfer(32'h00, 1'b1, 32'h0000_0011);
    ticks(1);
    chk_stat(4'b0000);
    ahb_xfer(32'h00, 1'b1, 32'h0000_0045);
    lvl <= 16'h0200;
    ticks(3);
    chk_stat(4'b0000);
    ahb_xfer(32'h00, 1'b1, 32'h0000_0001);
    ticks(1);
    chk_stat(4'b1000);
    final_report();
  end
endmodule : breaker_failure_monitor_tb_top
`default_nettype wire
